// ### verilog/reset_sequence_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Destructive reset with self test holds reset at least 6.2 ms, nominally 7.3 ms.
// - Destructive reset without self test holds reset at least 110 us, nominally 182 us.
// - Long external reset holds reset at least 6.2 ms, nominally 7.3 ms.
// - Long functional reset holds reset at least 110 us, nominally 182 us.
// - Short functional reset holds reset at least 7 us, nominally 9 us.
// - A functional reset drives the reset pin low until its count expires if its source may.
// - A functional reset whose source may not drive the pin leaves the pin undriven.
// - An outside generator holding the pin low keeps the device in reset until release.
module reset_sequence_timer
    import reset_seq_pkg::*;
#(
    parameter int DEST_BIST_CYC  = us_to_cycles(T_DEST_BIST_US),
    parameter int DEST_CYC       = us_to_cycles(T_DEST_US),
    parameter int EXT_LONG_CYC   = us_to_cycles(T_EXT_LONG_US),
    parameter int FUNC_LONG_CYC  = us_to_cycles(T_FUNC_LONG_US),
    parameter int FUNC_SHORT_CYC = us_to_cycles(T_FUNC_SHORT_US)
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire reset_req_s req,
    input  wire logic       reset_pin_n_in,
    output logic            reset_pin_n_out,
    output logic            reset_pin_n_oe,
    output logic            in_reset,
    output logic            seq_done,
    output reset_kind_e     active_kind
);
    seq_state_e         state;
    seq_state_e         next_state;
    logic               drive_pin;
    logic               load;
    logic [CNT_W-1:0]   load_value;
    logic               expired;

    // =====================================================
    // duration select
    // =====================================================
    always_comb begin
        load_value = CNT_W'(DEST_CYC);
        case (req.kind)
            KIND_DEST_BIST:  load_value = CNT_W'(DEST_BIST_CYC - 1);
            KIND_DEST:       load_value = CNT_W'(DEST_CYC - 1);
            KIND_EXT_LONG:   load_value = CNT_W'(EXT_LONG_CYC - 1);
            KIND_FUNC_LONG:  load_value = CNT_W'(FUNC_LONG_CYC - 1);
            KIND_FUNC_SHORT: load_value = CNT_W'(FUNC_SHORT_CYC - 1);
            default:         load_value = CNT_W'(DEST_CYC - 1);
        endcase
    end

    assign load = (state == ST_IDLE) && req.valid;

    seq_counter #(
        .W(CNT_W)
    ) u_counter (
        .clk        (clk),
        .nrst       (nrst),
        .load       (load),
        .load_value (load_value),
        .expired    (expired)
    );

    // =====================================================
    // sequence state
    // =====================================================
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  if (req.valid) next_state = ST_COUNT;
            ST_COUNT: if (expired) next_state = ST_HOLD;
            ST_HOLD:  if (reset_pin_n_in) next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            active_kind <= KIND_DEST;
        end else if (load) begin
            active_kind <= req.kind;
        end
    end

    // =====================================================
    // pin drive
    // =====================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drive_pin <= 1'b0;
        end else if (load) begin
            drive_pin <= req.pin_drive &&
                         (req.kind == KIND_FUNC_LONG || req.kind == KIND_FUNC_SHORT);
        end else if (state == ST_COUNT && expired) begin
            drive_pin <= 1'b0;
        end
    end

    assign reset_pin_n_oe  = drive_pin;
    assign reset_pin_n_out = 1'b0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_reset <= 1'b0;
            seq_done <= 1'b0;
        end else begin
            in_reset <= (next_state != ST_IDLE);
            seq_done <= (state == ST_HOLD) && reset_pin_n_in;
        end
    end

    // =====================================================
    // check helpers
    // =====================================================
    // cycles spent counting, for the length checks
    logic [CNT_W-1:0] count_len;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_len <= '0;
        end else if (load) begin
            count_len <= '0;
        end else if (state == ST_COUNT) begin
            count_len <= count_len + CNT_W'(1);
        end
    end

    // =====================================================
    // checks
    // =====================================================
    sequence s_start_short;
        load && req.kind == KIND_FUNC_SHORT;
    endsequence

    sequence s_count_end;
        state == ST_COUNT && expired;
    endsequence

    a_dest_bist_len: assert property (
        @(posedge clk) disable iff (!nrst)
        s_count_end ##0 active_kind == KIND_DEST_BIST
            |-> count_len == CNT_W'(DEST_BIST_CYC - 1)
    ) else $error("self test reset count length wrong");

    a_dest_len: assert property (
        @(posedge clk) disable iff (!nrst)
        s_count_end ##0 active_kind == KIND_DEST
            |-> count_len == CNT_W'(DEST_CYC - 1)
    ) else $error("destructive reset count length wrong");

    a_ext_long_len: assert property (
        @(posedge clk) disable iff (!nrst)
        s_count_end ##0 active_kind == KIND_EXT_LONG
            |-> count_len == CNT_W'(EXT_LONG_CYC - 1)
    ) else $error("long external reset count length wrong");

    a_func_long_len: assert property (
        @(posedge clk) disable iff (!nrst)
        s_count_end ##0 active_kind == KIND_FUNC_LONG
            |-> count_len == CNT_W'(FUNC_LONG_CYC - 1)
    ) else $error("long functional reset count length wrong");

    a_short_full_len: assert property (
        @(posedge clk) disable iff (!nrst)
        s_count_end ##0 active_kind == KIND_FUNC_SHORT
            |-> count_len == CNT_W'(FUNC_SHORT_CYC - 1)
    ) else $error("short functional reset count length wrong");

    a_drive_long: assert property (
        @(posedge clk) disable iff (!nrst)
        load && req.pin_drive && req.kind == KIND_FUNC_LONG |=> reset_pin_n_oe [*8]
    ) else $error("pin not driven during long functional reset");

    a_release_exit: assert property (
        @(posedge clk) disable iff (!nrst)
        state == ST_HOLD && reset_pin_n_in |=> !in_reset && seq_done
    ) else $error("reset held after count and pin release");

    a_short_min_len: assert property (
        @(posedge clk) disable iff (!nrst)
        s_start_short |=> in_reset [*8]
    ) else $error("short functional reset ended early");

    a_drive_functional: assert property (
        @(posedge clk) disable iff (!nrst)
        load && req.pin_drive && req.kind == KIND_FUNC_SHORT |=> reset_pin_n_oe [*8]
    ) else $error("pin not driven during functional reset");

    a_no_drive_dest: assert property (
        @(posedge clk) disable iff (!nrst)
        reset_pin_n_oe |-> (active_kind == KIND_FUNC_LONG || active_kind == KIND_FUNC_SHORT)
    ) else $error("pin driven for a non functional reset");

    a_no_drive_denied: assert property (
        @(posedge clk) disable iff (!nrst)
        load && !req.pin_drive |=> !reset_pin_n_oe
    ) else $error("pin driven without permission");

    a_hold_pin_low: assert property (
        @(posedge clk) disable iff (!nrst)
        state == ST_HOLD && !reset_pin_n_in |=> in_reset
    ) else $error("reset left while pin held low");

    a_end_needs_both: assert property (
        @(posedge clk) disable iff (!nrst)
        $fell(in_reset) |-> $past(expired) && $past(reset_pin_n_in)
    ) else $error("reset ended before count and pin release");

    a_short_exit: assert property (
        @(posedge clk) disable iff (!nrst)
        state == ST_COUNT && active_kind == KIND_FUNC_SHORT
            |-> count_len < CNT_W'(FUNC_SHORT_CYC)
    ) else $error("short functional reset overran");

    a_done_pulse: assert property (
        @(posedge clk) disable iff (!nrst)
        seq_done |-> !in_reset && $past(state == ST_HOLD)
    ) else $error("done without release");

endmodule : reset_sequence_timer

// ### verilog/reset_seq_pkg.sv
package reset_seq_pkg;

    // =====================================================
    // clock and timing
    // =====================================================
    localparam int CLK_HZ          = 50_000_000;
    localparam int CLK_PERIOD_NS   = 20;
    // minimum times, in microseconds
    localparam int T_DEST_BIST_US  = 6200;
    localparam int T_DEST_US       = 110;
    localparam int T_EXT_LONG_US   = 6200;
    localparam int T_FUNC_LONG_US  = 110;
    localparam int T_FUNC_SHORT_US = 7;
    // nominal times, in microseconds
    localparam int T_DEST_BIST_NOM_US  = 7300;
    localparam int T_DEST_NOM_US       = 182;
    localparam int T_EXT_LONG_NOM_US   = 7300;
    localparam int T_FUNC_LONG_NOM_US  = 182;
    localparam int T_FUNC_SHORT_NOM_US = 9;

    localparam int NS_PER_US = 1000;

    // least times round up to whole cycles
    function automatic int us_to_cycles(input int us);
        return (us * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : us_to_cycles

    localparam int CNT_W = 24;

    // =====================================================
    // reset kinds
    // =====================================================
    typedef enum logic [2:0] {
        KIND_DEST_BIST  = 3'h0,
        KIND_DEST       = 3'h1,
        KIND_EXT_LONG   = 3'h2,
        KIND_FUNC_LONG  = 3'h3,
        KIND_FUNC_SHORT = 3'h4
    } reset_kind_e;

    typedef struct packed {
        logic        valid;
        reset_kind_e kind;
        logic        pin_drive;
    } reset_req_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_COUNT = 2'b01,
        ST_HOLD  = 2'b11
    } seq_state_e;

endpackage : reset_seq_pkg

// ### verilog/seq_counter.sv
`timescale 1ns/1ps
module seq_counter
    import reset_seq_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic              expired
);
    logic [W-1:0] count;

    // =====================================================
    // down counter
    // =====================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    assign expired = (count == '0) && !load;

endmodule : seq_counter

// ### test/ext_reset_gen.sv
`timescale 1ns/1ps
module ext_reset_gen (
    input  wire logic        clk,
    input  wire logic        start,
    input  wire logic [15:0] len,
    output logic             pull_low
);
    logic [15:0] left = 16'h0;
    always_ff @(posedge clk) begin
        if (start) begin
            left <= len;
        end else if (left != 16'h0) begin
            left <= left - 16'h1;
        end
    end
    assign pull_low = (left != 16'h0);
endmodule : ext_reset_gen

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import reset_seq_pkg::*;
    localparam int NC [5] = '{40, 30, 45, 25, 350};
    typedef struct {int kind; int lo; int hi; int oe_n;} exp_s;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    reset_req_s  req = '0;
    logic        gen_start = 1'b0;
    logic [15:0] gen_len = 16'h0;
    logic        gen_low, pin_out, pin_oe, in_reset, seq_done;
    reset_kind_e active_kind;
    wire         pin_n = !((pin_oe && !pin_out) || gen_low);
    int          err_total = 0, checks = 0, cnt = 0, ocnt = 0, seed = 32'hAE06;
    exp_s        q [$];
    exp_s        e;
    always #10 clk = ~clk;
    reset_sequence_timer #(.DEST_BIST_CYC(NC[0]), .DEST_CYC(NC[1]), .EXT_LONG_CYC(NC[2]),
        .FUNC_LONG_CYC(NC[3]), .FUNC_SHORT_CYC(NC[4])) u_reset_sequence_timer (
        .clk(clk), .nrst(nrst), .req(req), .reset_pin_n_in(pin_n),
        .reset_pin_n_out(pin_out), .reset_pin_n_oe(pin_oe), .in_reset(in_reset),
        .seq_done(seq_done), .active_kind(active_kind));
    ext_reset_gen u_ext_reset_gen (.clk(clk), .start(gen_start), .len(gen_len),
        .pull_low(gen_low));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    // =====================================================
    // driver
    // =====================================================
    task automatic run(input int k, input logic drv, input int stretch);
        exp_s x;
        int   n;
        x.kind = k;
        x.oe_n = (k >= 3 && drv) ? NC[k] : 0;
        x.lo = (stretch > NC[k]) ? stretch : NC[k];
        x.hi = x.lo + 2;
        q.push_back(x);
        @(posedge clk); #2;
        req = {1'b1, reset_kind_e'(k), drv};
        gen_start = 1'b1;
        gen_len = 16'(stretch);
        @(posedge clk); #2;
        req.valid = 1'b0;
        gen_start = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        req = {1'b1, KIND_DEST_BIST, 1'b1};
        @(posedge clk); #2;
        req.valid = 1'b0;
        n = 0;
        while (seq_done !== 1'b1 && n < 2000) begin
            @(posedge clk); #2;
            n++;
        end
        check(n < 2000, 1); // bounded completion
        @(posedge clk);
        $display("test kind %0d drive %0d stretch %0d done", k, drv, stretch);
    endtask : run
    // =====================================================
    // monitor
    // =====================================================
    always @(posedge clk) begin
        if (nrst) begin
            if (in_reset === 1'b1) cnt++;
            if (pin_oe === 1'b1) ocnt++;
            if (seq_done === 1'b1) begin
                check(q.size() > 0, 1);
                if (q.size() > 0) begin
                    e = q.pop_front();
                    check(active_kind, e.kind);
                    check(cnt >= e.lo && cnt <= e.hi, 1);
                    check(ocnt, e.oe_n);
                end
                cnt = 0;
                ocnt = 0;
            end
        end
    end
    initial begin
        #400000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        #2;
        nrst = 1'b1;
        check(active_kind, KIND_DEST); // idle kind after reset
        check(in_reset, 0); // idle after reset
        for (int k = 0; k < 5; k++) begin
            for (int d = 0; d < 2; d++) run(k, d[0], 0);
        end
        for (int k = 0; k < 5; k++) run(k, $random(seed), NC[k] + 10 + ($random(seed) & 15));
        give_verdict();
    end
endmodule : tb_top
